// File: dacc_pkg.sv
// Constants and types for the dual converter control block
package dacc_pkg;
    // --------------------------------------------------------------
    // Sample coding
    // --------------------------------------------------------------
    localparam int SMP_W = 10;
    localparam int CODE_W = 8;
    localparam logic [SMP_W-1:0] FS_NEG = 10'h380;
    localparam logic [SMP_W-1:0] FS_POS = 10'h07F;
    localparam logic [SMP_W-1:0] MID_CODE = 10'h080;
    localparam logic [CODE_W-1:0] CODE_MIN = 8'h00;
    localparam logic [CODE_W-1:0] CODE_MAX = 8'hFF;
    localparam int LAT_PRI = 13;
    localparam int LAT_DLY = 14;
    // --------------------------------------------------------------
    // Calibration timing, in sample-clock cycles; BOOT_LAST in system-clock cycles
    // --------------------------------------------------------------
    localparam logic [6:0] TRIM_PHASE = 7'h50;
    localparam logic [15:0] CAL_LEN = 16'h0400;
    localparam logic [31:0] WAIT_SHORT_DEF = 32'h0200_0000;
    localparam logic [31:0] WAIT_LONG_DEF = 32'h8000_0000;
    localparam logic [1:0] BOOT_LAST = 2'h2;
    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] REG_CALCNT = 4'h8;
    localparam int CTRL_W = 4;
    localparam int CTRL_DRIVE = 0;
    localparam int CTRL_EDGE = 1;
    localparam int CTRL_SPAN = 2;
    localparam int CTRL_WAIT = 3;
    localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
    localparam int STAT_W = 5;
    localparam int CNT_W = 16;
    typedef enum logic [1:0] {ST_BOOT, ST_WAIT, ST_IDLE, ST_CAL} dacc_state_t;
endpackage

// File: dacc_top.sv
// Calibration sequencing, sample coding and output demultiplexing
`timescale 1ns/1ps
// Behaviour
// - Out-of-span inputs give all-zeros or all-ones
// - One range flag for either channel
// - Each channel split over two half-rate buses
// - Power-up and command calibration trim alike
// - No calibration start or run in power-down
// - Command is 80 low then 80 high
// - Pin high at boot blocks power-up calibration
// - Power-up wait 2^25 or 2^31 cycles
// - Power-down at boot freezes wait counter
// - Trim flag high throughout any calibration
// - Sample latency 13 primary, 14 delayed
// - Output words are offset binary
// - Converts on every sample clock outside power-down, no start
// - Register mode ignores the four pin settings
// - Power-down deferred until calibration ends
// - Q sleep leaves Q untrimmed until recalibrated
module dacc_top #(
    parameter logic [31:0] PWRUP_WAIT_SHORT = dacc_pkg::WAIT_SHORT_DEF,
    parameter logic [31:0] PWRUP_WAIT_LONG = dacc_pkg::WAIT_LONG_DEF
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic sample_clk_i,
    input wire logic [dacc_pkg::SMP_W-1:0] i_diff_i,
    input wire logic [dacc_pkg::SMP_W-1:0] q_diff_i,
    input wire logic trim_command_pin_i,
    input wire logic power_down_pin_i,
    input wire logic q_channel_sleep_i,
    input wire logic input_span_select_i,
    input wire logic drive_strength_select_i,
    input wire logic launch_edge_select_i,
    input wire logic powerup_trim_wait_select_i,
    input wire logic reg_ctrl_mode_i,
    input wire logic [dacc_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [dacc_pkg::CODE_W-1:0] i_primary_bus_o,
    output logic [dacc_pkg::CODE_W-1:0] i_delayed_bus_o,
    output logic [dacc_pkg::CODE_W-1:0] q_primary_bus_o,
    output logic [dacc_pkg::CODE_W-1:0] q_delayed_bus_o,
    output logic range_exceeded_flag_o,
    output logic trim_active_flag_o,
    output logic power_down_o,
    output logic drive_strength_o,
    output logic launch_edge_o,
    output logic input_span_o
);
    import dacc_pkg::*;

    localparam int PIN_W = 2 * SMP_W + 9;

    // --------------------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------------------
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s1_q;
    logic [PIN_W-1:0] pin_s2_q;
    logic clk_s, trim_s, pd_s, qsleep_s, span_s, drive_s, edge_s, waitsel_s, mode_s;
    logic [SMP_W-1:0] i_s, q_s;
    logic clk_d_q;
    logic sample_evt;

    assign pin_raw = {sample_clk_i, trim_command_pin_i, power_down_pin_i, q_channel_sleep_i,
        input_span_select_i, drive_strength_select_i, launch_edge_select_i,
        powerup_trim_wait_select_i, reg_ctrl_mode_i, q_diff_i, i_diff_i};
    assign {clk_s, trim_s, pd_s, qsleep_s, span_s, drive_s, edge_s, waitsel_s, mode_s,
        q_s, i_s} = pin_s2_q;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            clk_d_q <= 1'b0;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            clk_d_q <= clk_s;
        end
    end

    // Falling edge of the sample clock acquires
    assign sample_evt = clk_d_q & ~clk_s;

    // --------------------------------------------------------------
    // Registers and settings
    // --------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl_q;
    logic reg_mode_q;
    logic pu_block_q;
    logic q_trimmed_q;
    logic q_slept_q;
    logic [CNT_W-1:0] cal_count_q;
    logic [31:0] rd_mux;
    logic wait_sel;

    // Pins are ignored once register mode was strapped
    assign wait_sel = reg_mode_q ? ctrl_q[CTRL_WAIT] : waitsel_s;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            drive_strength_o <= 1'b0;
            launch_edge_o <= 1'b0;
            input_span_o <= 1'b0;
        end else begin
            drive_strength_o <= reg_mode_q ? ctrl_q[CTRL_DRIVE] : drive_s;
            launch_edge_o <= reg_mode_q ? ctrl_q[CTRL_EDGE] : edge_s;
            input_span_o <= reg_mode_q ? ctrl_q[CTRL_SPAN] : span_s;
        end
    end

    always_comb begin
        rd_mux = '0;
        case (avs_address_i)
            REG_CTRL: rd_mux[CTRL_W-1:0] = ctrl_q;
            REG_STATUS: rd_mux[STAT_W-1:0] = {range_exceeded_flag_o, reg_mode_q, q_trimmed_q,
                power_down_o, trim_active_flag_o};
            REG_CALCNT: rd_mux[CNT_W-1:0] = cal_count_q;
            default: rd_mux = '0;
        endcase
    end

    // One wait state per access, unmapped reads give zero
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= '0;
        end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o <= avs_read_i ? rd_mux : '0;
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ctrl_q <= CTRL_RST;
        end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == REG_CTRL
                && avs_byteenable_i[0]) begin
            ctrl_q <= avs_writedata_i[CTRL_W-1:0];
        end
    end

    // --------------------------------------------------------------
    // Trim command detector
    // --------------------------------------------------------------
    logic [6:0] low_cnt_q;
    logic [6:0] hi_cnt_q;
    logic cmd_valid;

    assign cmd_valid = sample_evt && trim_s && low_cnt_q == TRIM_PHASE
        && hi_cnt_q == TRIM_PHASE - 7'h1;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            low_cnt_q <= '0;
            hi_cnt_q <= '0;
        end else if (sample_evt) begin
            if (!trim_s) begin
                hi_cnt_q <= '0;
                if (low_cnt_q != TRIM_PHASE) begin
                    low_cnt_q <= low_cnt_q + 7'h1;
                end
            end else if (low_cnt_q != TRIM_PHASE) begin
                low_cnt_q <= '0;
            end else if (cmd_valid) begin
                low_cnt_q <= '0;
                hi_cnt_q <= '0;
            end else begin
                hi_cnt_q <= hi_cnt_q + 7'h1;
            end
        end
    end

    // --------------------------------------------------------------
    // Calibration sequencer
    // --------------------------------------------------------------
    dacc_state_t state_q, state_d;
    logic [1:0] boot_cnt_q;
    logic [31:0] wait_cnt_q;
    logic [31:0] wait_last;
    logic [15:0] cal_cnt_q;
    logic wait_done;
    logic cal_done;

    assign wait_last = (wait_sel ? PWRUP_WAIT_LONG : PWRUP_WAIT_SHORT) - 32'h1;
    assign wait_done = state_q == ST_WAIT && sample_evt && !pd_s && wait_cnt_q == wait_last;
    assign cal_done = state_q == ST_CAL && state_d == ST_IDLE;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_BOOT: begin
                if (boot_cnt_q == BOOT_LAST) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (cmd_valid && !pd_s) begin
                    state_d = ST_CAL;
                end else if (wait_done) begin
                    state_d = pu_block_q ? ST_IDLE : ST_CAL;
                end
            end
            ST_IDLE: begin
                // Same sequence serves both causes
                if (cmd_valid && !pd_s) begin
                    state_d = ST_CAL;
                end
            end
            ST_CAL: begin
                if (sample_evt && cal_cnt_q == CAL_LEN - 16'h1) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_q <= ST_BOOT;
            trim_active_flag_o <= 1'b0;
        end else begin
            state_q <= state_d;
            trim_active_flag_o <= state_d == ST_CAL;
        end
    end

    // Straps wait for the synchroniser to fill; the mode is read once only
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            boot_cnt_q <= '0;
            pu_block_q <= 1'b0;
            reg_mode_q <= 1'b0;
        end else if (state_q == ST_BOOT) begin
            boot_cnt_q <= boot_cnt_q + 2'h1;
            if (boot_cnt_q == BOOT_LAST) begin
                pu_block_q <= trim_s;
                reg_mode_q <= mode_s;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            wait_cnt_q <= '0;
        end else if (state_q == ST_WAIT && sample_evt && !pd_s) begin
            wait_cnt_q <= wait_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cal_cnt_q <= '0;
        end else if (state_q != ST_CAL) begin
            cal_cnt_q <= '0;
        end else if (sample_evt) begin
            cal_cnt_q <= cal_cnt_q + 16'h1;
        end
    end

    // Power-down waits for a running trim to finish
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            power_down_o <= 1'b0;
        end else if (!pd_s) begin
            power_down_o <= 1'b0;
        end else if (state_d != ST_CAL) begin
            power_down_o <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            cal_count_q <= '0;
            q_slept_q <= 1'b0;
            q_trimmed_q <= 1'b0;
        end else begin
            if (cal_done) begin
                cal_count_q <= cal_count_q + 16'h1;
            end
            if (state_q != ST_CAL) begin
                q_slept_q <= 1'b0;
            end else if (qsleep_s) begin
                q_slept_q <= 1'b1;
            end
            if (qsleep_s) begin
                q_trimmed_q <= 1'b0;
            end else if (cal_done && !q_slept_q) begin
                q_trimmed_q <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------------
    // Sample coding, pipeline and demultiplexer
    // --------------------------------------------------------------
    function automatic logic [CODE_W:0] conv(input logic [SMP_W-1:0] v);
        logic [SMP_W-1:0] sum;
        sum = v + MID_CODE;
        if ($signed(v) < $signed(FS_NEG)) begin
            conv = {1'b1, CODE_MIN};
        end else if ($signed(v) > $signed(FS_POS)) begin
            conv = {1'b1, CODE_MAX};
        end else begin
            conv = {1'b0, sum[CODE_W-1:0]};
        end
    endfunction

    logic [CODE_W-1:0] i_pipe_q [0:LAT_DLY-1];
    logic [CODE_W-1:0] q_pipe_q [0:LAT_DLY-1];
    logic [LAT_DLY-1:0] flag_pipe_q;
    logic [CODE_W:0] i_cv, q_cv;
    logic phase_q;
    logic shift_en;
    logic out_upd;

    // A sleeping Q channel repeats its last word and never flags
    assign i_cv = conv(i_s);
    assign q_cv = qsleep_s ? {1'b0, q_pipe_q[0]} : conv(q_s);
    assign shift_en = sample_evt && !power_down_o;
    assign out_upd = shift_en && phase_q;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            for (int k = 0; k < LAT_DLY; k++) begin
                i_pipe_q[k] <= '0;
                q_pipe_q[k] <= '0;
            end
            flag_pipe_q <= '0;
            phase_q <= 1'b0;
        end else if (shift_en) begin
            for (int k = LAT_DLY - 1; k > 0; k--) begin
                i_pipe_q[k] <= i_pipe_q[k-1];
                q_pipe_q[k] <= q_pipe_q[k-1];
            end
            i_pipe_q[0] <= i_cv[CODE_W-1:0];
            q_pipe_q[0] <= q_cv[CODE_W-1:0];
            flag_pipe_q <= {flag_pipe_q[LAT_DLY-2:0], i_cv[CODE_W] | q_cv[CODE_W]};
            phase_q <= ~phase_q;
        end
    end

    // Older word of each pair goes to the delayed bus; outputs hold in power-down
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            i_primary_bus_o <= '0;
            i_delayed_bus_o <= '0;
            q_primary_bus_o <= '0;
            q_delayed_bus_o <= '0;
            range_exceeded_flag_o <= 1'b0;
        end else if (out_upd) begin
            i_primary_bus_o <= i_pipe_q[LAT_PRI-1];
            q_primary_bus_o <= q_pipe_q[LAT_PRI-1];
            i_delayed_bus_o <= i_pipe_q[LAT_DLY-1];
            q_delayed_bus_o <= q_pipe_q[LAT_DLY-1];
            range_exceeded_flag_o <= flag_pipe_q[LAT_PRI-1] | flag_pipe_q[LAT_DLY-1];
        end
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    sat_low_a: assert property (
        shift_en && $signed(i_s) < $signed(FS_NEG) |=> i_pipe_q[0] == CODE_MIN && flag_pipe_q[0])
        else $error("low input not clamped to zero code");
    sat_high_a: assert property (
        shift_en && !qsleep_s && $signed(q_s) > $signed(FS_POS)
        |=> q_pipe_q[0] == CODE_MAX && flag_pipe_q[0])
        else $error("high input not clamped to full code");
    offset_code_a: assert property (
        shift_en && $signed(i_s) >= $signed(FS_NEG) && $signed(i_s) <= $signed(FS_POS)
        |=> i_pipe_q[0] == {~$past(i_s[CODE_W-1]), $past(i_s[CODE_W-2:0])})
        else $error("in-range code not offset binary");
    range_or_a: assert property (
        out_upd |=> range_exceeded_flag_o
            == ($past(flag_pipe_q[LAT_PRI-1]) || $past(flag_pipe_q[LAT_DLY-1])))
        else $error("range flag does not follow pair");
    demux_phase_a: assert property (
        $changed(i_primary_bus_o) |-> $past(shift_en && phase_q))
        else $error("primary bus changed off its phase");
    pipe_flow_a: assert property (
        shift_en |=> i_pipe_q[LAT_PRI] == $past(i_pipe_q[LAT_PRI-1]))
        else $error("pipeline did not advance");
    cmd_len_a: assert property (
        $rose(trim_active_flag_o) && !$past(wait_done) |-> $past(hi_cnt_q) == TRIM_PHASE - 7'h1)
        else $error("command calibration without full high phase");
    trim_cause_a: assert property (
        $rose(trim_active_flag_o) |-> $past(cmd_valid || wait_done))
        else $error("trim flag rose without a cause");
    pd_no_start_a: assert property (
        !trim_active_flag_o && pd_s |=> !trim_active_flag_o)
        else $error("calibration started in power-down");
    pd_defer_a: assert property (
        trim_active_flag_o |-> !power_down_o)
        else $error("power-down entered during calibration");
    wait_hold_a: assert property (
        state_q == ST_WAIT && pd_s |=> $stable(wait_cnt_q))
        else $error("wait counter ran in power-down");
    pu_block_a: assert property (
        wait_done && pu_block_q && !cmd_valid |=> !trim_active_flag_o)
        else $error("blocked power-up calibration ran");
    q_untrim_a: assert property (
        qsleep_s |=> !q_trimmed_q)
        else $error("Q reported trimmed while asleep");
    pin_lock_a: assert property (
        reg_mode_q ##1 reg_mode_q |-> input_span_o == $past(ctrl_q[CTRL_SPAN]))
        else $error("span pin not locked out");

    cmd_cal_c: cover property (cmd_valid && state_q == ST_IDLE ##1 trim_active_flag_o);
    pwrup_cal_c: cover property (wait_done && !pu_block_q ##1 trim_active_flag_o);
    range_c: cover property (out_upd ##1 range_exceeded_flag_o);
    pd_defer_c: cover property (trim_active_flag_o && pd_s ##1 !trim_active_flag_o);
endmodule

// File: dacc_capture_model.sv
// Capture-side model that rebuilds the full-rate stream from both buses
`timescale 1ns/1ps
module dacc_capture_model (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic sample_clk_i,
    input wire logic [7:0] i_primary_bus_i,
    input wire logic [7:0] i_delayed_bus_i,
    input wire logic [7:0] q_primary_bus_i,
    input wire logic [7:0] q_delayed_bus_i,
    input wire logic range_i,
    output logic cap_stb_o,
    output int cap_acq_o,
    output logic [15:0] i_word_o,
    output logic [15:0] q_word_o,
    output logic range_o
);
    int n;
    initial begin
        n = 0;
        cap_stb_o = 1'b0;
        cap_acq_o = 0;
        i_word_o = '0;
        q_word_o = '0;
        range_o = 1'b0;
    end
    // -----------------------------------------------------------------
    // Capture
    // -----------------------------------------------------------------
    // Read well clear of the update, which lands a few cycles after a fall
    always begin
        @(negedge sample_clk_i);
        n = srst_i ? 0 : n + 1;
        repeat (6) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        if (n[0] == 1'b0 && n > 0) begin
            // Older word first
            i_word_o = {i_delayed_bus_i, i_primary_bus_i};
            q_word_o = {q_delayed_bus_i, q_primary_bus_i};
            range_o = range_i;
            cap_acq_o = n - 1;
            cap_stb_o = 1'b1;
            @(negedge sys_clk_i);
            cap_stb_o = 1'b0;
        end
    end
endmodule

// File: tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb;
    import dacc_pkg::*;
    typedef struct {
        logic [9:0] i_in;
        logic [9:0] q_in;
        logic [7:0] i_exp;
        logic [7:0] q_exp;
        logic ovr;
    } dacc_row_t;
    localparam logic [31:0] WSHORT = 32'h40;
    localparam logic [31:0] WLONG = 32'h80;
    logic sys_clk = 1'b0, srst = 1'b1, sclk = 1'b0, sclk_en = 1'b0, chk_on = 1'b0;
    logic [9:0] i_diff = '0, q_diff = '0;
    logic trim = 1'b1, pd = 1'b0, qs = 1'b0, span = 1'b1, drv = 1'b1, edg = 1'b0;
    logic wsel = 1'b0, mode = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [3:0] addr = '0;
    logic [31:0] wdata = '0, rdata;
    logic waitreq, rng, trim_act, pdo, drv_o, edg_o, span_o, cap_stb, rng_c;
    logic cal_seen = 1'b0, pd_seen = 1'b0;
    logic [7:0] ip, idl, qp, qd;
    logic [15:0] iw, qw;
    int cap_acq, ro, rn, error_cnt = 0, samples_checked = 0, cap_cnt = 0;
    // Saturating offset binary codes, range flag per row
    dacc_row_t rows [10] = '{
        '{10'h000, 10'h000, 8'h80, 8'h80, 1'b0}, '{10'h07F, 10'h380, 8'hFF, 8'h00, 1'b0},
        '{10'h080, 10'h000, 8'hFF, 8'h80, 1'b1}, '{10'h37F, 10'h001, 8'h00, 8'h81, 1'b1},
        '{10'h3FF, 10'h1FF, 8'h7F, 8'hFF, 1'b1}, '{10'h001, 10'h200, 8'h81, 8'h00, 1'b1},
        '{10'h040, 10'h3C0, 8'hC0, 8'h40, 1'b0}, '{10'h3FF, 10'h07E, 8'h7F, 8'hFE, 1'b0},
        '{10'h200, 10'h1FF, 8'h00, 8'hFF, 1'b1}, '{10'h0AA, 10'h355, 8'hFF, 8'h00, 1'b1}};
    dacc_top #(.PWRUP_WAIT_SHORT(WSHORT), .PWRUP_WAIT_LONG(WLONG)) i_dut (
        .sys_clk_i(sys_clk), .srst_i(srst), .sample_clk_i(sclk), .i_diff_i(i_diff),
        .q_diff_i(q_diff), .trim_command_pin_i(trim), .power_down_pin_i(pd),
        .q_channel_sleep_i(qs), .input_span_select_i(span), .drive_strength_select_i(drv),
        .launch_edge_select_i(edg), .powerup_trim_wait_select_i(wsel),
        .reg_ctrl_mode_i(mode), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata),
        .avs_waitrequest_o(waitreq), .i_primary_bus_o(ip), .i_delayed_bus_o(idl),
        .q_primary_bus_o(qp), .q_delayed_bus_o(qd), .range_exceeded_flag_o(rng),
        .trim_active_flag_o(trim_act), .power_down_o(pdo), .drive_strength_o(drv_o),
        .launch_edge_o(edg_o), .input_span_o(span_o));
    dacc_capture_model i_cap (
        .sys_clk_i(sys_clk), .srst_i(srst), .sample_clk_i(sclk), .i_primary_bus_i(ip),
        .i_delayed_bus_i(idl), .q_primary_bus_i(qp), .q_delayed_bus_i(qd), .range_i(rng),
        .cap_stb_o(cap_stb), .cap_acq_o(cap_acq), .i_word_o(iw), .q_word_o(qw),
        .range_o(rng_c));
    always #10 sys_clk = ~sys_clk;
    // Odd offset keeps the link clock clear of system edges
    initial begin
        #7;
        forever #80 if (sclk_en) sclk = ~sclk;
    end
    // -----------------------------------------------------------------
    // Stream checking
    // -----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (chk_on && cap_stb === 1'b1) cap_cnt++;
        if (chk_on && cap_stb === 1'b1 && cap_acq >= 15) begin
            ro = (cap_acq - 14) % 10;
            rn = (cap_acq - 13) % 10;
            `CHK(iw, {rows[ro].i_exp, rows[rn].i_exp})
            `CHK(qw, {rows[ro].q_exp, rows[rn].q_exp})
            `CHK(rng_c, rows[ro].ovr | rows[rn].ovr)
        end
        if (trim_act === 1'b1) cal_seen <= 1'b1;
    end
    task automatic end_sim;
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic rst_dut;
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic falls(input int k);
        repeat (k) @(negedge sclk);
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic cmd(input int lo, input int hi);
        @(posedge sclk);
        @(posedge sys_clk);
        trim <= 1'b0;
        repeat (lo) @(negedge sclk);
        @(posedge sclk);
        @(posedge sys_clk);
        trim <= 1'b1;
        falls(hi);
    endtask
    task automatic wait_flag(input logic val, output int k);
        k = 0;
        while (trim_act !== val) begin
            if (k > 1500) begin
                error_cnt++;
                end_sim();
            end
            @(negedge sclk);
            k++;
            repeat (6) @(posedge sys_clk);
            if (pdo === 1'b1 && trim_act === 1'b1) pd_seen = 1'b1;
        end
    endtask
    task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] wd,
                       output logic [31:0] rv);
        int t;
        t = 0;
        addr <= a;
        wdata <= wd;
        wr <= we;
        rd <= ~we;
        @(posedge sys_clk);
        while (waitreq !== 1'b0) begin
            t++;
            if (t > 20) begin
                error_cnt++;
                end_sim();
            end
            @(posedge sys_clk);
        end
        rv = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge sys_clk);
    endtask
    initial begin
        int n;
        logic [31:0] v;
        rst_dut();
        sclk_en = 1'b1;
        chk_on <= 1'b1;
        for (int k = 0; k < 72; k++) begin
            @(posedge sclk);
            @(posedge sys_clk);
            i_diff <= rows[k % 10].i_in;
            q_diff <= rows[k % 10].q_in;
        end
        falls(2);
        chk_on <= 1'b0;
        `CHK(cap_cnt, 36)
        `CHK(cal_seen, 1'b0)
        `CHK({drv_o, edg_o, span_o}, 3'b101)
        $display("test stream done");
        cmd(79, 80);
        `CHK(trim_act, 1'b0)
        pd <= 1'b1;
        cmd(80, 80);
        `CHK({trim_act, pdo}, 2'b01)
        pd <= 1'b0;
        // Span moved, so the command that follows is owed
        span <= 1'b0;
        cmd(80, 80);
        `CHK(trim_act, 1'b1)
        `CHK(span_o, 1'b0)
        pd <= 1'b1;
        wait_flag(1'b0, n);
        `CHK(pd_seen, 1'b0)
        `CHK(n >= CAL_LEN - 2 && n <= CAL_LEN + 2, 1'b1)
        falls(1);
        `CHK(pdo, 1'b1)
        pd <= 1'b0;
        bus(1'b0, REG_CALCNT, '0, v);
        `CHK(v, 32'h1)
        bus(1'b0, REG_STATUS, '0, v);
        `CHK(v[2], 1'b1)
        qs <= 1'b1;
        // Sleep pin crosses the synchroniser before the flag drops
        repeat (4) @(posedge sys_clk);
        bus(1'b0, REG_STATUS, '0, v);
        `CHK(v[2], 1'b0)
        qs <= 1'b0;
        $display("test command calibration done");
        for (int s = 0; s < 2; s++) begin
            trim <= 1'b0;
            pd <= 1'b1;
            wsel <= s[0];
            rst_dut();
            falls(140);
            `CHK(trim_act, 1'b0)
            pd <= 1'b0;
            wait_flag(1'b1, n);
            v = s ? WLONG : WSHORT;
            `CHK(n >= v - 2 && n <= v + 2, 1'b1)
        end
        $display("test power-up wait done");
        // Mode changes only across a reset
        mode <= 1'b1;
        trim <= 1'b1;
        rst_dut();
        bus(1'b1, REG_CTRL, 32'h2, v);
        repeat (2) @(posedge sys_clk);
        `CHK({drv_o, edg_o, span_o}, 3'b010)
        bus(1'b0, REG_CTRL, '0, v);
        `CHK(v, 32'h2)
        // Unmapped place reads as zero
        bus(1'b0, 4'hC, '0, v);
        `CHK(v, 32'h0)
        $display("test register mode done");
        end_sim();
    end
endmodule
